// file: src/block_move_pkg.sv
package block_move_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcode fields of the first instruction word
    localparam logic [6:0] OPC_DATA_TO_DATA = 7'h54;   // upper seven bits, bit 8 picks direction
    localparam logic [7:0] OPC_PROG_TO_DATA = 8'hA5;   // upper eight bits
    localparam int OPC_DD_LSB = 9;
    localparam int OPC_PD_LSB = 8;
    localparam int IMM_DST_BIT = 8;                    // set: long immediate is the destination
    localparam int FORM_BIT = 7;                       // set: indirect form
    localparam int DMA_W = 7;                          // direct offset width
    localparam int ARU_LSB = 4;
    localparam int NEXT_FLAG_BIT = 3;
    localparam int NAR_LSB = 0;
    localparam int DP_W = 9;                           // data page width, page plus offset make 16 bits

    ////////////////////////////////////////////////////////////////////////////
    // aux update codes
    localparam logic [2:0] ARU_NONE = 3'h0;
    localparam logic [2:0] ARU_DEC = 3'h1;
    localparam logic [2:0] ARU_INC = 3'h2;
    localparam logic [2:0] ARU_REV_ADD = 3'h3;
    localparam logic [2:0] ARU_REV_SUB = 3'h4;
    localparam logic [2:0] ARU_SUB_IDX = 3'h5;
    localparam logic [2:0] ARU_ADD_IDX = 3'h6;
    localparam logic [2:0] INDEX_REG = 3'h0;           // index register is register 0

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte offsets within the slave
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_RPT = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DP = 8'h14;
    localparam logic [7:0] OFF_EXT_BASE = 8'h18;
    localparam logic [7:0] OFF_ARP = 8'h1C;
    localparam logic [7:0] OFF_AR_BASE = 8'h20;
    localparam logic [7:0] AR_BLOCK_MASK = 8'hE0;
    localparam logic [7:0] OFF_CONFIG = 8'h40;
    localparam int AR_SEL_LSB = 2;
    localparam int WORD_LSB = 16;

    // control and status bit positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PREFIX_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_INHIBIT_BIT = 1;
    localparam int ST_ERROR_BIT = 2;
    localparam int ST_STACK_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and steps
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] EXT_BASE_RESET = 16'h8000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // memory port carriers
    typedef struct packed {
        logic valid;
        logic prog;          // program space when set, data space otherwise
        logic [15:0] addr;
    } mem_rd_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } mem_wr_req_t;

    localparam mem_rd_req_t RD_IDLE = '0;
    localparam mem_wr_req_t WR_IDLE = '0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_DECODE,
        S_CONFLICT,
        S_MOVE,
        S_TAIL
    } move_state_t;

endpackage

// file: src/aux_address_unit.sv
`timescale 1ns/1ps
`default_nettype none
module aux_address_unit
    import block_move_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // software load
    input wire logic wr_en_i,
    input wire logic [2:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic arp_wr_en_i,
    input wire logic [2:0] arp_wr_data_i,
    // per-transfer update
    input wire logic upd_i,
    input wire logic [2:0] aru_i,
    input wire logic next_en_i,
    input wire logic [2:0] nar_i,
    // views
    input wire logic [2:0] rd_sel_i,
    output logic [15:0] rd_data_o,
    output logic [15:0] cur_ar_o,
    output logic [2:0] arp_o
);

    ////////////////////////////////////////////////////////////////////////////
    // bit reversal for reverse-carry arithmetic
    function automatic logic [15:0] bitrev(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int k = 0; k < 16; k++) begin
            r[k] = v[15 - k];
        end
        return r;
    endfunction

    logic [15:0] ar [8];        // auxiliary registers
    logic [2:0] aux_register_pointer;            // aux register pointer
    logic [15:0] index_val;     // index register contents
    logic [15:0] next_cur;      // updated current register

    assign cur_ar_o = ar[aux_register_pointer];
    assign index_val = ar[INDEX_REG];
    assign rd_data_o = ar[rd_sel_i];
    assign arp_o = aux_register_pointer;

    ////////////////////////////////////////////////////////////////////////////
    // the seven indirect options; unused code leaves the register alone
    always_comb begin
        case (aru_i)
            ARU_DEC: next_cur = cur_ar_o - PC_STEP;
            ARU_INC: next_cur = cur_ar_o + PC_STEP;
            ARU_ADD_IDX: next_cur = cur_ar_o + index_val;
            ARU_SUB_IDX: next_cur = cur_ar_o - index_val;
            ARU_REV_ADD: next_cur = bitrev(bitrev(cur_ar_o) + bitrev(index_val));
            ARU_REV_SUB: next_cur = bitrev(bitrev(cur_ar_o) - bitrev(index_val));
            default: next_cur = cur_ar_o;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // register file, one slot per generate step; software load wins over update
    for (genvar g = 0; g < 8; g++) begin : g_ar
        always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
                ar[g] <= WORD_ZERO;
            end else if (wr_en_i && wr_sel_i == 3'(g)) begin
                ar[g] <= wr_data_i;
            end else if (upd_i && aux_register_pointer == 3'(g)) begin
                ar[g] <= next_cur;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer moves to the named register after the access
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            aux_register_pointer <= 3'h0;
        end else if (arp_wr_en_i) begin
            aux_register_pointer <= arp_wr_data_i;
        end else if (upd_i && next_en_i) begin
            aux_register_pointer <= nar_i;
        end
    end

endmodule
`default_nettype wire

// file: src/block_move_instruction_unit.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - data-to-data move: bit 8 picks immediate direction
// - bit 7 selects direct or indirect form
// - program move: second word is source address
// - direct form gives seven low address bits
// - next-register field picks register zero to seven
// - seven indirect update options supported
// - stack pc, immediate into pc, restore after
// - repeat count plus one transfers, decrementing
// - indirect side updates, direct side stays fixed
// - interrupts held off during repeated moves
// - one word per cycle once pipeline runs
// - any mix of on-chip and external blocks
// - single data move three cycles, more external
// - repeated data move n+2, external costs more
// - single program move three cycles base
// - repeated program move n+2, conflict n+4
module block_move_instruction_unit
    import block_move_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic [1:0] hresp_o,
    // memory read port
    output mem_rd_req_t rd_req_o,
    input wire logic rd_ready_i,
    input wire logic [15:0] rd_data_i,
    // memory write port
    output mem_wr_req_t wr_req_o,
    input wire logic wr_ready_i,
    // sequencer
    output logic busy_o,
    output logic irq_inhibit_o,
    output logic done_o
);

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic bus_take;             // valid address phase
    logic wr_q;                 // write data phase pending
    logic [7:0] wa_q;           // captured write offset
    logic [31:0] rd_mux;        // read value chosen in address phase

    assign bus_take = hsel_i & htrans_i[1] & hready_i;

    // zero-wait slave; sizes other than a word are treated as a word
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hrdata_o <= BUS_ZERO;
            hreadyout_o <= 1'b0;
            hresp_o <= RESP_OKAY;
        end else begin
            wr_q <= bus_take & hwrite_i;
            wa_q <= haddr_i[7:0];
            hreadyout_o <= 1'b1;
            hresp_o <= RESP_OKAY;
            if (bus_take && !hwrite_i) begin
                hrdata_o <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-visible state
    logic [31:0] instr;         // both instruction words
    logic [15:0] repeat_prefix;           // repeat count register
    logic [15:0] pc;            // program counter
    logic [15:0] micro_stack;   // saved return pc
    logic [DP_W-1:0] dp;        // data page for direct form
    logic [15:0] ext_base;      // data addresses at or above are external
    logic cfg_share;            // destination shares a single-access block with code
    logic prefix;               // repeat prefix, loaded by the same control write that starts the move
    logic err;                  // start refused, unknown opcode
    move_state_t state;

    logic idle;
    logic w_ctrl, w_instr, w_rpt, w_pc, w_dp, w_ext, w_arp, w_ar, w_cfg;
    logic start_ok, start_bad;

    assign idle = (state == S_IDLE);
    // writes to live state are dropped while a move runs
    assign w_ctrl = wr_q & (wa_q == OFF_CTRL);
    assign w_instr = wr_q & idle & (wa_q == OFF_INSTR);
    assign w_rpt = wr_q & idle & (wa_q == OFF_RPT);
    assign w_pc = wr_q & idle & (wa_q == OFF_PC);
    assign w_dp = wr_q & idle & (wa_q == OFF_DP);
    assign w_ext = wr_q & idle & (wa_q == OFF_EXT_BASE);
    assign w_arp = wr_q & idle & (wa_q == OFF_ARP);
    assign w_ar = wr_q & idle & ((wa_q & AR_BLOCK_MASK) == OFF_AR_BASE);
    assign w_cfg = wr_q & idle & (wa_q == OFF_CONFIG);

    ////////////////////////////////////////////////////////////////////////////
    // instruction decode
    logic [15:0] w0, w1;
    logic is_dd, is_pd, legal, imm_is_dst, indirect;
    logic [15:0] direct_addr, other_addr, cur_ar, ar_view;
    logic [2:0] aux_register_pointer;

    assign w0 = instr[15:0];
    assign w1 = instr[31:WORD_LSB];
    assign is_dd = (w0[15:OPC_DD_LSB] == OPC_DATA_TO_DATA);
    assign is_pd = (w0[15:OPC_PD_LSB] == OPC_PROG_TO_DATA);
    assign legal = is_dd | is_pd;
    assign imm_is_dst = is_dd & w0[IMM_DST_BIT];
    assign indirect = w0[FORM_BIT];
    assign direct_addr = {dp, w0[DMA_W-1:0]};
    assign other_addr = indirect ? cur_ar : direct_addr;

    assign start_ok = w_ctrl & idle & hwdata_i[CTRL_START_BIT] & legal;
    assign start_bad = w_ctrl & idle & hwdata_i[CTRL_START_BIT] & ~legal;

    ////////////////////////////////////////////////////////////////////////////
    // transfer pipeline control
    logic first_q;              // first transfer still owed
    logic more;                 // another read must be issued
    logic stall;                // a presented request is not yet taken
    logic rd_acc, wr_acc;       // requests taken this cycle
    logic ext_wr, ext_rd;       // external access just completed
    logic can_issue, finish;
    logic [15:0] src_addr, dst_addr, rd_dst_q;
    logic repeated;

    assign src_addr = imm_is_dst ? other_addr : pc;
    assign dst_addr = imm_is_dst ? pc : other_addr;
    assign more = first_q | (prefix & (repeat_prefix != WORD_ZERO));
    assign repeated = prefix & (repeat_prefix != WORD_ZERO);
    assign stall = (rd_req_o.valid & ~rd_ready_i) | (wr_req_o.valid & ~wr_ready_i);
    assign rd_acc = rd_req_o.valid & rd_ready_i;
    assign wr_acc = wr_req_o.valid & wr_ready_i;
    // an external access costs the next issue slot, giving the slower rates
    assign ext_wr = wr_acc & (wr_req_o.addr >= ext_base);
    assign ext_rd = rd_acc & ~rd_req_o.prog & (rd_req_o.addr >= ext_base);
    // on-chip: a read and the previous write overlap, one word per cycle
    assign can_issue = (state == S_MOVE) & ~stall & more & ~ext_wr & ~ext_rd;
    assign finish = (state == S_MOVE) & ~stall & ~more & ~rd_req_o.valid;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing state machine
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: if (start_ok) begin
                    state <= S_DECODE;
                end
                // one cycle saving pc; a shared block costs one more
                S_DECODE: state <= cfg_share ? S_CONFLICT : S_MOVE;
                S_CONFLICT: state <= S_MOVE;
                S_MOVE: if (finish) begin
                    state <= (cfg_share && !first_q && prefix) ? S_TAIL : S_IDLE;
                end
                S_TAIL: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pc and micro-stack
    logic restore;
    assign restore = (finish && !(cfg_share && prefix)) || (state == S_TAIL);

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pc <= WORD_ZERO;
            micro_stack <= WORD_ZERO;
        end else if (w_pc) begin
            pc <= hwdata_i[15:0];
        end else if (state == S_DECODE) begin
            micro_stack <= pc + PC_STEP;
            pc <= w1;
        end else if (can_issue) begin
            pc <= pc + PC_STEP;
        end else if (restore) begin
            pc <= micro_stack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // repeat count and first-transfer flag
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            repeat_prefix <= WORD_ZERO;
            first_q <= 1'b0;
        end else begin
            if (w_rpt) begin
                repeat_prefix <= hwdata_i[15:0];
            end else if (can_issue && !first_q) begin
                repeat_prefix <= repeat_prefix - CNT_STEP;
            end
            if (state == S_DECODE) begin
                first_q <= 1'b1;
            end else if (can_issue) begin
                first_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory requests; a taken read becomes next cycle's write
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rd_req_o <= RD_IDLE;
            wr_req_o <= WR_IDLE;
            rd_dst_q <= WORD_ZERO;
        end else if (!stall) begin
            wr_req_o <= rd_acc ? mem_wr_req_t'{valid: 1'b1, addr: rd_dst_q, data: rd_data_i} : WR_IDLE;
            if (can_issue) begin
                rd_req_o <= '{valid: 1'b1, prog: is_pd, addr: src_addr};
                rd_dst_q <= dst_addr;
            end else begin
                rd_req_o <= RD_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags and sequencer outputs
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
            irq_inhibit_o <= 1'b0;
            done_o <= 1'b0;
            err <= 1'b0;
        end else begin
            busy_o <= ~restore & (busy_o | start_ok);
            done_o <= restore;
            if (state == S_DECODE) begin
                irq_inhibit_o <= repeated;
            end else if (restore) begin
                irq_inhibit_o <= 1'b0;
            end
            // a fresh refusal wins over a clear in the same write
            err <= start_bad | (err & ~start_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain configuration registers
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            instr <= BUS_ZERO;
            dp <= '0;
            ext_base <= EXT_BASE_RESET;
            cfg_share <= 1'b0;
            prefix <= 1'b0;
        end else begin
            if (w_instr) begin
                instr <= hwdata_i;
            end
            if (w_dp) begin
                dp <= hwdata_i[DP_W-1:0];
            end
            if (w_ext) begin
                ext_base <= hwdata_i[15:0];
            end
            if (w_cfg) begin
                cfg_share <= hwdata_i[0];
            end
            if (w_ctrl && idle) begin
                prefix <= hwdata_i[CTRL_PREFIX_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // auxiliary registers; only the indirect side moves per transfer
    aux_address_unit u_aux (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .wr_en_i(w_ar),
        .wr_sel_i(wa_q[AR_SEL_LSB+2:AR_SEL_LSB]),
        .wr_data_i(hwdata_i[15:0]),
        .arp_wr_en_i(w_arp),
        .arp_wr_data_i(hwdata_i[2:0]),
        .upd_i(can_issue & indirect),
        .aru_i(w0[ARU_LSB+2:ARU_LSB]),
        .next_en_i(w0[NEXT_FLAG_BIT]),
        .nar_i(w0[NAR_LSB+2:NAR_LSB]),
        .rd_sel_i(haddr_i[AR_SEL_LSB+2:AR_SEL_LSB]),
        .rd_data_o(ar_view),
        .cur_ar_o(cur_ar),
        .arp_o(aux_register_pointer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read decode; unmapped offsets return zero
    logic [31:0] status_word;
    assign status_word = {micro_stack, 13'h0000, err, irq_inhibit_o, busy_o};

    always_comb begin
        rd_mux = BUS_ZERO;
        if ((haddr_i[7:0] & AR_BLOCK_MASK) == OFF_AR_BASE) begin
            rd_mux = {16'h0000, ar_view};
        end else begin
            case (haddr_i[7:0])
                OFF_CTRL: rd_mux = {30'h0000_0000, prefix, 1'b0};
                OFF_INSTR: rd_mux = instr;
                OFF_RPT: rd_mux = {16'h0000, repeat_prefix};
                OFF_PC: rd_mux = {16'h0000, pc};
                OFF_STATUS: rd_mux = status_word;
                OFF_DP: rd_mux = {23'h00_0000, dp};
                OFF_EXT_BASE: rd_mux = {16'h0000, ext_base};
                OFF_ARP: rd_mux = {29'h0000_0000, aux_register_pointer};
                OFF_CONFIG: rd_mux = {31'h0000_0000, cfg_share};
                default: rd_mux = BUS_ZERO;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: bench/block_move_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module block_move_asserts
    import block_move_pkg::*;
(
    // watched ports of the move unit
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic hreadyout_o,
    input wire logic [1:0] hresp_o,
    input wire mem_rd_req_t rd_req_o,
    input wire logic rd_ready_i,
    input wire logic [15:0] rd_data_i,
    input wire mem_wr_req_t wr_req_o,
    input wire logic wr_ready_i,
    input wire logic busy_o,
    input wire logic irq_inhibit_o,
    input wire logic done_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // zero wait okay answer once out of reset
    chk_bus_okay: assert property (!$past(reset_i) |-> hreadyout_o && hresp_o == RESP_OKAY)
        else $error("bus answer late or not okay");
    chk_read_held: assert property (rd_req_o.valid && !rd_ready_i |=> rd_req_o == $past(rd_req_o))
        else $error("read request dropped while stalled");
    chk_write_held: assert property (wr_req_o.valid && !wr_ready_i |=> wr_req_o == $past(wr_req_o))
        else $error("write request dropped while stalled");
    chk_word_pairs: assert property (rd_req_o.valid && rd_ready_i |=> wr_req_o.valid && wr_req_o.data == $past(rd_data_i))
        else $error("read word not written next cycle");
    chk_pc_step: assert property ((rd_req_o.valid && rd_req_o.prog && rd_ready_i) ##1 (rd_req_o.valid && rd_req_o.prog)
        |-> rd_req_o.addr == $past(rd_req_o.addr) + PC_STEP)
        else $error("program source address did not step by one");
    chk_inhibit_busy: assert property (irq_inhibit_o |-> busy_o)
        else $error("inhibit outside a move");
    chk_done_pulse: assert property ($fell(busy_o) |-> done_o ##1 !done_o)
        else $error("done not a single pulse at move end");
    chk_quiet_idle: assert property (!busy_o |-> !rd_req_o.valid && !wr_req_o.valid)
        else $error("memory request while idle");
    cov_done: cover property (done_o);
    cov_inhibit: cover property (irq_inhibit_o);
    cov_stall: cover property (rd_req_o.valid && !rd_ready_i);
endmodule
bind block_move_instruction_unit block_move_asserts chk_u (.*);
`default_nettype wire

// file: bench/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import block_move_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // stall every other cycle when set
    input wire logic slow_i,
    // memory link
    input wire mem_rd_req_t rd_req_i,
    output logic rd_ready_o,
    output logic [15:0] rd_data_o,
    output logic wr_ready_o
);
    logic [15:0] last_q; // value driven on rd_data_o in the previous cycle
    logic [15:0] word; // plain memory only, no registers behind it
    assign word = rd_req_i.addr ^ (rd_req_i.prog ? 16'h5A5A : 16'hC3C3);
    // outside an accepted read show the inverse, never a stale match
    assign rd_data_o = (rd_req_i.valid && rd_ready_o) ? word : ~last_q;
    assign wr_ready_o = rd_ready_o;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rd_ready_o <= 1'b1;
            last_q <= 16'h0000;
        end else begin
            rd_ready_o <= slow_i ? ~rd_ready_o : 1'b1;
            last_q <= rd_data_o;
        end
    end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import block_move_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, hreadyout, rd_ready, wr_ready, busy, inhibit, done;
    logic [1:0] htrans = 2'h0, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [15:0] rd_data, wa[$], wd[$];
    mem_rd_req_t rd_req;
    mem_wr_req_t wr_req;
    int n_mismatch = 0, tests_run = 0, busy_n, inh_n;
    always #25 clock_i = ~clock_i;
    block_move_instruction_unit dut_u (.clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hreadyout), .hwdata_i(hwdata),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .rd_req_o(rd_req), .rd_ready_i(rd_ready),
        .rd_data_i(rd_data), .wr_req_o(wr_req), .wr_ready_i(wr_ready), .busy_o(busy), .irq_inhibit_o(inhibit),
        .done_o(done));
    mem_model mem_u (.clock_i(clock_i), .reset_i(reset_i), .slow_i(slow), .rd_req_i(rd_req),
        .rd_ready_o(rd_ready), .rd_data_o(rd_data), .wr_ready_o(wr_ready));
    // log every accepted write
    always @(posedge clock_i) begin
        if (wr_req.valid && wr_ready) begin
            wa.push_back(wr_req.addr);
            wd.push_back(wr_req.data);
        end
    end
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait on a flag, counted at each settled edge
    task automatic wait_for(input bit on_done);
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            busy_n += int'(busy === 1'b1);
            inh_n += int'(inhibit === 1'b1);
            n++;
        end while ((on_done ? done : hreadyout) !== 1'b1 && n < 100);
        if ((on_done ? done : hreadyout) !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // one ahb-lite single word transfer, held until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_for(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_for(1'b0);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask
    // start a move and count busy and inhibit cycles up to done
    task automatic run_move(input logic [31:0] ctrl);
        wa.delete();
        wd.delete();
        wr(OFF_CTRL, ctrl);
        busy_n = 0;
        inh_n = 0;
        wait_for(1'b1);
    endtask
    task automatic t_single();
        rd_chk("ext base", OFF_EXT_BASE, 32'h0000_8000);
        wr(OFF_DP, 32'h0000_0006);
        wr(OFF_INSTR, {16'h0100, OPC_DATA_TO_DATA, 2'b00, 7'h05});
        run_move(32'h0000_0001);
        check("busy cycles", 32'h3, busy_n);
        check("dest", 32'h0305, wa[0]);
        check("data", 32'h0100 ^ 32'hC3C3, wd[0]);
        // same move again, destination sharing a block with code
        wr(OFF_CONFIG, 32'h0000_0001);
        run_move(32'h0000_0001);
        check("shared busy cycles", 32'h4, busy_n);
        check("shared dest", 32'h0305, wa[0]);
        wr(OFF_CONFIG, 32'h0);
        $display("single move test done");
    endtask
    task automatic t_repeat();
        wr(OFF_PC, 32'h0000_0050);
        wr(OFF_RPT, 32'h0000_0003);
        wr(OFF_AR_BASE + 8'h0C, 32'h0000_0200);
        wr(OFF_ARP, 32'h0000_0003);
        wr(OFF_INSTR, {16'h0400, OPC_PROG_TO_DATA, 1'b1, ARU_INC, 1'b1, 3'd3});
        run_move(32'h0000_0003);
        check("busy cycles", 32'h6, busy_n);
        check("inhibit cycles", 32'h6, inh_n);
        check("writes", 32'h4, wa.size());
        for (int i = 0; i < 4; i++) begin
            check("dest", 32'h0200 + i, wa[i]);
            check("data", (32'h0400 + i) ^ 32'h5A5A, wd[i]);
        end
        rd_chk("pc", OFF_PC, 32'h0000_0051);
        rd_chk("count", OFF_RPT, 32'h0);
        rd_chk("ar3", OFF_AR_BASE + 8'h0C, 32'h0000_0204);
        $display("repeated move test done");
    endtask
    task automatic t_zero();
        wr(OFF_RPT, 32'h0);
        wr(OFF_INSTR, {16'h0700, OPC_DATA_TO_DATA, 1'b1, 1'b1, ARU_DEC, 1'b0, 3'd0});
        slow <= 1'b1;
        run_move(32'h0000_0003);
        slow <= 1'b0;
        check("inhibit", 32'h0, inh_n);
        check("writes", 32'h1, wa.size());
        check("dest", 32'h0700, wa[0]);
        check("data", 32'h0204 ^ 32'hC3C3, wd[0]);
        rd_chk("ar3", OFF_AR_BASE + 8'h0C, 32'h0000_0203);
        $display("zero count test done");
    endtask
    // unknown opcode: start refused, error flag set, saved pc kept
    task automatic t_refuse();
        wr(OFF_INSTR, 32'h0);
        wr(OFF_CTRL, 32'h0000_0001);
        rd_chk("status", OFF_STATUS, 32'h0052_0004);
        $display("refused start test done");
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        t_single();
        t_repeat();
        t_zero();
        t_refuse();
        give_verdict();
    end
endmodule
`default_nettype wire
